// ===== hdl/wcc_map.svh
/*
  register map, field positions and reset values of the window comparator
  channel control block; assumes one 32-bit apb word per register
*/
`ifndef WCC_MAP_SVH
`define WCC_MAP_SVH
`define WCC_OFF_CHB      12'h000
`define WCC_OFF_CHC      12'h004
`define WCC_OFF_IRQ_STAT 12'h008
`define WCC_OFF_IRQ_CLR  12'h00c
`define WCC_OFF_IRQ_EN   12'h010
`define WCC_OFF_PROT     12'h014
`define WCC_FILT_LSB     16
`define WCC_FILT_MSB     20
`define WCC_ENA_BIT      15
`define WCC_PEMG_BIT     11
`define WCC_MEMG_BIT     10
`define WCC_TSEL_BIT     9
`define WCC_IRQEN_BIT    8
`define WCC_WEN_BIT      7
`define WCC_FLAG_BIT     5
`define WCC_HR_BIT       3
`define WCC_LR_BIT       2
`define WCC_HL_BIT       1
`define WCC_LL_BIT       0
`define WCC_CFG_RESET    32'h0000_0000
`define WCC_THR_W        8
`endif

// ===== hdl/wcc_pkg.sv
/*
  types shared by the window comparator channel control block;
  assumes wcc_map.svh supplies the numeric layout
*/
package wcc_pkg;
  typedef struct packed {
    logic [4:0] output_pulse_filter;
    logic       comparator_enable;
    logic       pfc_emergency_route;
    logic       motor_emergency_route;
    logic       threshold_set_select;
    logic       irq_enable;
    logic       latched_irq_flag;
    logic       high_trip_latched;
    logic       low_trip_latched;
  } wcc_chan_t;
  typedef struct packed {
    logic [7:0] upper_threshold;
    logic [7:0] lower_threshold;
  } wcc_thr_t;
  typedef enum logic [1:0] {
    WCC_IDLE  = 2'b00,
    WCC_SETUP = 2'b01,
    WCC_DONE  = 2'b10
  } wcc_apb_state_t;
endpackage

// ===== hdl/wcc_ctrl.sv
/*
  control and status logic for window comparator channels b and c, apb slave.
  assumes raw high/low comparator bits arrive synchronous to sys_clk
  (sys_clk is the converter clock) and thresholds come from outside.
*/
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "wcc_map.svh"
module wcc_ctrl
  import wcc_pkg::*;
#(
  parameter int FILT_W = 5
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  high_trip_raw,
  input  wire logic [1:0]  low_trip_raw,
  input  wire wcc_thr_t    thr_set0,
  input  wire wcc_thr_t    thr_set1,
  output wcc_thr_t         thr_sel_b,
  output wcc_thr_t         thr_sel_c,
  output logic             pfc_hiz,
  output logic             motor_emergency,
  output logic             irq
);
  // elaboration check: the filter field is five bits wide
  if (FILT_W != 5) begin : g_filt_w_check
    $error("wcc_ctrl: filter field is five bits");
  end

  wcc_chan_t      ch_reg   [2];
  logic [1:0]     live_h_reg;
  logic [1:0]     live_l_reg;
  logic [FILT_W-1:0] cnt_reg [2];
  logic [1:0]     chan_out;
  logic [1:0]     irq_stat_reg;
  logic [1:0]     irq_en_reg;
  logic           emg_gate_reg;
  logic           pfc_hiz_reg;
  logic           motor_emg_reg;
  logic           irq_reg;
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;
  wcc_apb_state_t st_reg;
  logic           wr_hit;
  logic [1:0]     trip_h;
  logic [1:0]     trip_l;

  function automatic logic [31:0] pack_chan(input wcc_chan_t c, input logic h, input logic l);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`WCC_FILT_MSB:`WCC_FILT_LSB] = c.output_pulse_filter;
    w[`WCC_ENA_BIT]    = c.comparator_enable;
    w[`WCC_PEMG_BIT]   = c.pfc_emergency_route;
    w[`WCC_MEMG_BIT]   = c.motor_emergency_route;
    w[`WCC_TSEL_BIT]   = c.threshold_set_select;
    w[`WCC_IRQEN_BIT]  = c.irq_enable;
    w[`WCC_FLAG_BIT]   = c.latched_irq_flag;
    w[`WCC_HR_BIT]     = c.high_trip_latched;
    w[`WCC_LR_BIT]     = c.low_trip_latched;
    w[`WCC_HL_BIT]     = h;
    w[`WCC_LL_BIT]     = l;
    return w;
  endfunction

  // apb handshake: setup then one access cycle with pready high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg     <= WCC_IDLE;
      pready_reg <= 1'b0;
    end else begin
      case (st_reg)
        WCC_IDLE: begin
          pready_reg <= 1'b0;
          if (psel && !penable) begin
            st_reg     <= WCC_SETUP;
            pready_reg <= 1'b1;
          end
        end
        WCC_SETUP: begin
          st_reg     <= WCC_DONE;
          pready_reg <= 1'b0;
        end
        WCC_DONE: begin
          st_reg     <= WCC_IDLE;
          pready_reg <= 1'b0;
          if (psel && !penable) begin
            st_reg     <= WCC_SETUP;
            pready_reg <= 1'b1;
          end
        end
        default: begin
          st_reg     <= WCC_IDLE;
          pready_reg <= 1'b0;
        end
      endcase
    end
  end

  assign wr_hit = psel && penable && pready_reg && pwrite;

  // read data and error, latched in setup
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_reg <= 1'b0;
      case (paddr)
        `WCC_OFF_CHB:      prdata_reg <= pack_chan(ch_reg[0], live_h_reg[0], live_l_reg[0]);
        `WCC_OFF_CHC:      prdata_reg <= pack_chan(ch_reg[1], live_h_reg[1], live_l_reg[1]);
        `WCC_OFF_IRQ_STAT: prdata_reg <= {30'h0, irq_stat_reg};
        `WCC_OFF_IRQ_CLR:  prdata_reg <= 32'h0000_0000;
        `WCC_OFF_IRQ_EN:   prdata_reg <= {30'h0, irq_en_reg};
        `WCC_OFF_PROT:     prdata_reg <= {31'h0, emg_gate_reg};
        default: begin
          prdata_reg  <= 32'h0000_0000;
          pslverr_reg <= 1'b1;
        end
      endcase
    end
  end

  // live trips gated by enable, window outside test
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      live_h_reg <= 2'b00;
      live_l_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        live_h_reg[i] <= high_trip_raw[i] && ch_reg[i].comparator_enable;
        live_l_reg[i] <= low_trip_raw[i] && ch_reg[i].comparator_enable;
      end
    end
  end

  // pulse width filter per channel
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!(live_h_reg[i] || live_l_reg[i]))
          cnt_reg[i] <= '0;
        else if (cnt_reg[i] < ch_reg[i].output_pulse_filter)
          cnt_reg[i] <= cnt_reg[i] + 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // outside window means above upper or below lower
      chan_out[i] = (live_h_reg[i] || live_l_reg[i]) &&
                    (cnt_reg[i] >= ch_reg[i].output_pulse_filter);
    end
    trip_h = live_h_reg & chan_out;
    trip_l = live_l_reg & chan_out;
  end

  // channel registers: config, latched bits
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ch_reg[0] <= wcc_chan_t'(`WCC_CFG_RESET);
      ch_reg[1] <= wcc_chan_t'(`WCC_CFG_RESET);
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_hit && paddr == (i == 0 ? `WCC_OFF_CHB : `WCC_OFF_CHC)) begin
          if (!pwdata[`WCC_WEN_BIT]) begin
            ch_reg[i].output_pulse_filter   <= pwdata[`WCC_FILT_MSB:`WCC_FILT_LSB];
            ch_reg[i].comparator_enable     <= pwdata[`WCC_ENA_BIT];
            ch_reg[i].pfc_emergency_route   <= pwdata[`WCC_PEMG_BIT];
            ch_reg[i].motor_emergency_route <= pwdata[`WCC_MEMG_BIT];
            ch_reg[i].threshold_set_select  <= pwdata[`WCC_TSEL_BIT];
            ch_reg[i].irq_enable            <= pwdata[`WCC_IRQEN_BIT];
          end
          // writing 0 clears; writing 1 keeps
          ch_reg[i].latched_irq_flag  <= ch_reg[i].latched_irq_flag && pwdata[`WCC_FLAG_BIT];
          ch_reg[i].high_trip_latched <= ch_reg[i].high_trip_latched && pwdata[`WCC_HR_BIT];
          ch_reg[i].low_trip_latched  <= ch_reg[i].low_trip_latched && pwdata[`WCC_LR_BIT];
        end
        // set wins over clear
        if (trip_h[i])
          ch_reg[i].high_trip_latched <= 1'b1;
        if (trip_l[i])
          ch_reg[i].low_trip_latched <= 1'b1;
        if (trip_h[i] || trip_l[i])
          ch_reg[i].latched_irq_flag <= 1'b1;
      end
    end
  end

  // block-level sticky status, enable, clear, protection gate
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_stat_reg <= 2'b00;
      irq_en_reg   <= 2'b00;
      emg_gate_reg <= 1'b0;
    end else begin
      if (wr_hit && paddr == `WCC_OFF_IRQ_EN)
        irq_en_reg <= pwdata[1:0];
      if (wr_hit && paddr == `WCC_OFF_PROT)
        emg_gate_reg <= pwdata[0];
      irq_stat_reg <= (irq_stat_reg & ~((wr_hit && paddr == `WCC_OFF_IRQ_CLR) ? pwdata[1:0] : 2'b00))
                      | (trip_h | trip_l);
    end
  end

  // outputs from flip-flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pfc_hiz_reg   <= 1'b0;
      motor_emg_reg <= 1'b0;
      irq_reg       <= 1'b0;
      thr_sel_b     <= '0;
      thr_sel_c     <= '0;
    end else begin
      pfc_hiz_reg <= (chan_out[0] && ch_reg[0].pfc_emergency_route) ||
                     (chan_out[1] && ch_reg[1].pfc_emergency_route);
      motor_emg_reg <= emg_gate_reg &&
                       ((chan_out[0] && ch_reg[0].motor_emergency_route) ||
                        (chan_out[1] && ch_reg[1].motor_emergency_route));
      irq_reg <= (ch_reg[0].latched_irq_flag && ch_reg[0].irq_enable) ||
                 (ch_reg[1].latched_irq_flag && ch_reg[1].irq_enable) ||
                 |(irq_stat_reg & irq_en_reg);
      thr_sel_b <= ch_reg[0].threshold_set_select ? thr_set1 : thr_set0;
      thr_sel_c <= ch_reg[1].threshold_set_select ? thr_set1 : thr_set0;
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign pfc_hiz         = pfc_hiz_reg;
  assign motor_emergency = motor_emg_reg;
  assign irq             = irq_reg;

  a_disable_zero: assert property (@(posedge sys_clk) disable iff (reset)
    !ch_reg[0].comparator_enable |=> !live_h_reg[0] && !live_l_reg[0])
    else $error("disabled channel b shows a trip");
  a_nofilter_pass: assert property (@(posedge sys_clk) disable iff (reset)
    ch_reg[0].output_pulse_filter == 5'h00 && live_h_reg[0] |-> chan_out[0])
    else $error("unfiltered trip not passed");
  a_filter_width: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(live_h_reg[0]) && ch_reg[0].output_pulse_filter == 5'h04 |-> !chan_out[0] [*4])
    else $error("filtered pulse passed too early");
  a_pfc_route_b: assert property (@(posedge sys_clk) disable iff (reset)
    chan_out[0] && ch_reg[0].pfc_emergency_route |=> pfc_hiz)
    else $error("pfc hi-z missing for channel b");
  a_pfc_route_c: assert property (@(posedge sys_clk) disable iff (reset)
    chan_out[1] && ch_reg[1].pfc_emergency_route |=> pfc_hiz)
    else $error("pfc hi-z missing for channel c");
  a_motor_gate: assert property (@(posedge sys_clk) disable iff (reset)
    !emg_gate_reg |=> !motor_emergency)
    else $error("motor emergency without gate");
  a_thr_select: assert property (@(posedge sys_clk) disable iff (reset)
    ch_reg[0].threshold_set_select |=> thr_sel_b == $past(thr_set1))
    else $error("wrong threshold set");
  a_wen_keep: assert property (@(posedge sys_clk) disable iff (reset)
    wr_hit && paddr == `WCC_OFF_CHB && pwdata[`WCC_WEN_BIT] |=> $stable(ch_reg[0].irq_enable))
    else $error("config changed by masked write");
  a_flag_hold: assert property (@(posedge sys_clk) disable iff (reset)
    ch_reg[0].latched_irq_flag && !wr_hit |=> ch_reg[0].latched_irq_flag)
    else $error("flag dropped without clear");
  a_high_latch: assert property (@(posedge sys_clk) disable iff (reset)
    trip_h[0] |=> ch_reg[0].high_trip_latched)
    else $error("high trip not latched");
  a_low_latch: assert property (@(posedge sys_clk) disable iff (reset)
    trip_l[0] |=> ch_reg[0].low_trip_latched)
    else $error("low trip not latched");
  a_irq_line: assert property (@(posedge sys_clk) disable iff (reset)
    ch_reg[0].latched_irq_flag && ch_reg[0].irq_enable |=> irq)
    else $error("irq missing");
  c_trip_b: cover property (@(posedge sys_clk) trip_h[0]);
  c_clear_flag: cover property (@(posedge sys_clk) $fell(ch_reg[0].latched_irq_flag));
  c_pfc: cover property (@(posedge sys_clk) $rose(pfc_hiz));
endmodule // wcc_ctrl

// ===== test/wcc_comparator_model.sv
/*
  behavioural model of the two analog window comparators beside the block;
  assumes the bench holds the input levels and the dut supplies the selected set
*/
`timescale 1ns/1ns
module wcc_comparator_model
  import wcc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] level_b,
  input  wire logic [7:0] level_c,
  input  wire wcc_thr_t   thr_sel_b,
  input  wire wcc_thr_t   thr_sel_c,
  output logic      [1:0] high_trip_raw,
  output logic      [1:0] low_trip_raw
);
  // compare against whichever set the block selected
  always_ff @(posedge sys_clk) begin
    high_trip_raw <= {level_c > thr_sel_c.upper_threshold,
                      level_b > thr_sel_b.upper_threshold};
    low_trip_raw  <= {level_c < thr_sel_c.lower_threshold,
                      level_b < thr_sel_b.lower_threshold};
  end
endmodule // wcc_comparator_model

// ===== test/tb_window_comparator_channel_ctrl.sv
/*
  directed testbench of the window comparator channel control block;
  assumes wcc_pkg, wcc_ctrl and the comparator model are compiled first
*/
`timescale 1ns/1ns
`include "wcc_map.svh"
module tb_window_comparator_channel_ctrl
  import wcc_pkg::*;
;
  logic        sys_clk;
  logic        reset;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  high_trip_raw;
  logic [1:0]  low_trip_raw;
  wcc_thr_t    thr_set0;
  wcc_thr_t    thr_set1;
  wcc_thr_t    thr_sel_b;
  wcc_thr_t    thr_sel_c;
  logic        pfc_hiz;
  logic        motor_emergency;
  logic        irq;
  logic [7:0]  level_b;
  logic [7:0]  level_c;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        saw;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  wcc_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_trip_raw(high_trip_raw),
    .low_trip_raw(low_trip_raw), .thr_set0(thr_set0), .thr_set1(thr_set1),
    .thr_sel_b(thr_sel_b), .thr_sel_c(thr_sel_c), .pfc_hiz(pfc_hiz),
    .motor_emergency(motor_emergency), .irq(irq));

  wcc_comparator_model cmp (.sys_clk(sys_clk), .level_b(level_b), .level_c(level_c),
    .thr_sel_b(thr_sel_b), .thr_sel_c(thr_sel_c),
    .high_trip_raw(high_trip_raw), .low_trip_raw(low_trip_raw));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task stop_test;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] addr, input logic [31:0] data);
    xfer(1'b1, addr, data);
  endtask

  task rd(input logic [11:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0000_0000);
    check(rd_data, exp);
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  initial begin
    reset = 1'b1; paddr = 12'h000; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    pwdata = 32'h0; thr_set0 = 16'h8020; thr_set1 = 16'hc060;
    level_b = 8'h40; level_c = 8'h40;
    tick(5);
    reset <= 1'b0;
    rd(`WCC_OFF_CHB, 32'h0000_0000);
    rd(`WCC_OFF_CHC, 32'h0000_0000);
    rd(12'h020, 32'h0000_0000);
    check(32'(rd_err), 32'h1);
    wr(`WCC_OFF_CHB, 32'h0000_8d00);
    rd(`WCC_OFF_CHB, 32'h0000_8d00);
    wr(`WCC_OFF_CHB, 32'h001f_0080);
    rd(`WCC_OFF_CHB, 32'h0000_8d00);
    // high trip, no filter
    level_b <= 8'hf0;
    tick(6);
    check(32'(pfc_hiz), 32'h1);
    check(32'(irq), 32'h1);
    check(32'(motor_emergency), 32'h0);
    wr(`WCC_OFF_PROT, 32'h0000_0001);
    tick(3);
    check(32'(motor_emergency), 32'h1);
    rd(`WCC_OFF_CHB, 32'h0000_8d2a);
    level_b <= 8'h40;
    tick(6);
    check(32'(pfc_hiz), 32'h0);
    rd(`WCC_OFF_CHB, 32'h0000_8d28);
    wr(`WCC_OFF_CHB, 32'h0000_8c00);
    rd(`WCC_OFF_CHB, 32'h0000_8c00);
    // shared status, enable and clear
    rd(`WCC_OFF_IRQ_STAT, 32'h0000_0001);
    check(32'(irq), 32'h0);
    wr(`WCC_OFF_IRQ_EN, 32'h0000_0001);
    tick(2);
    check(32'(irq), 32'h1);
    wr(`WCC_OFF_IRQ_CLR, 32'h0000_0001);
    tick(2);
    check(32'(irq), 32'h0);
    rd(`WCC_OFF_IRQ_STAT, 32'h0000_0000);
    wr(`WCC_OFF_IRQ_EN, 32'h0000_0000);
    // trip with channel interrupt disabled
    level_b <= 8'hf0;
    tick(6);
    check(32'(irq), 32'h0);
    wr(`WCC_OFF_CHB, 32'h0000_8d2c);
    tick(2);
    check(32'(irq), 32'h1);
    level_b <= 8'h40;
    // reference set 1 makes 0x40 a low trip
    wr(`WCC_OFF_CHB, 32'h0000_8e00);
    tick(6);
    check({16'h0000, thr_sel_b}, {16'h0000, thr_set1});
    check(32'(pfc_hiz), 32'h1);
    rd(`WCC_OFF_CHB, 32'h0000_8e25);
    // filter of four clocks
    wr(`WCC_OFF_CHB, 32'h0004_8800);
    tick(6);
    check(32'(pfc_hiz), 32'h0);
    level_b <= 8'hf0;
    tick(2);
    level_b <= 8'h40;
    saw = 1'b0;
    repeat (10) begin
      @(posedge sys_clk);
      saw = saw | pfc_hiz;
    end
    check(32'(saw), 32'h0);
    level_b <= 8'hf0;
    tick(12);
    check(32'(pfc_hiz), 32'h1);
    // disabled channel b stays quiet, channel c drives the pfc path
    wr(`WCC_OFF_CHB, 32'h0000_0800);
    tick(6);
    check(32'(pfc_hiz), 32'h0);
    wr(`WCC_OFF_CHC, 32'h0000_8800);
    level_c <= 8'hf0;
    tick(6);
    check(32'(pfc_hiz), 32'h1);
    check({16'h0000, thr_sel_c}, {16'h0000, thr_set0});
    rd(`WCC_OFF_CHC, 32'h0000_882a);
    stop_test();
  end
endmodule // tb_window_comparator_channel_ctrl
